// ===== design/obg_buzzer.sv
// Functional notes
// - writing the sound buffer clears buffer-empty and, in one-shot mode, starts output
// - buffer moves into working register only on a sound clock tick
// - that load sets buffer-empty and busy together
// - while busy the pin carries a rectangular wave from the loaded fields
// - after the duration the tone stops, done set, busy cleared at once
// - high time is high-period field plus one sound ticks
// - period is period field plus one sound ticks
//
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module obg_buzzer #(
	parameter int SND_DIV = obg_pkg::OBG_SND_DIV,
	parameter int DUR_UNIT = obg_pkg::OBG_DUR_UNIT
) (
	input wire logic sys_clk, // system clock, 125 MHz
	input wire logic resetn, // async reset, active low
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // write enable
	input wire logic [4:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // one-cycle acknowledge
	output logic buzzer_out, // buzzer pin
	output logic irq // level interrupt
);
	import obg_pkg::*;

	// ==========================================================
	// bus decode
	logic ack_r;
	logic [31:0] rdat_r;
	wire bus_req = wb_cyc_i && wb_stb_i && !ack_r;
	// writes land at the ack edge: the master is certain to hold its data there,
	// and the single-cycle ack means each access is applied exactly once
	wire wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
	wire wr_ctrl = wr && (wb_adr_i == OBG_ADR_CTRL);
	wire wr_sbuf = wr && (wb_adr_i == OBG_ADR_SBUF);
	wire wr_iclr = wr && (wb_adr_i == OBG_ADR_ICLR) && wb_sel_i[0];
	wire wr_ien = wr && (wb_adr_i == OBG_ADR_IEN) && wb_sel_i[0];

	// ==========================================================
	// sound clock tick divider
	localparam int DIVW = $clog2(SND_DIV + 1);
	localparam logic [DIVW-1:0] DIV_LAST = DIVW'(SND_DIV - 1);
	logic [DIVW-1:0] div_r;
	logic tick_r;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			div_r <= '0;
			tick_r <= 1'b0;
		end else begin
			div_r <= (div_r == DIV_LAST) ? '0 : div_r + 1'b1;
			tick_r <= (div_r == DIV_LAST);
		end
	end

	// ==========================================================
	// control and sound buffer registers
	logic [1:0] mode_r;
	logic [3:0] tempo_r;
	obg_snd_t sbuf_r;
	logic pend_r;
	logic busy_r;
	wire load = tick_r && pend_r && (mode_r == OBG_MODE_ONESHOT);
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mode_r <= OBG_MODE_RST;
			tempo_r <= OBG_TEMPO_RST;
			sbuf_r <= '0;
			pend_r <= 1'b0;
		end else begin
			if (wr_ctrl && wb_sel_i[0]) begin
				mode_r <= wb_dat_i[OBG_MODE_LSB +: 2];
				tempo_r <= wb_dat_i[OBG_TEMPO_LSB +: 4];
			end
			if (wr_sbuf && wb_sel_i[0])
				sbuf_r.high <= wb_dat_i[OBG_HIGH_LSB +: 6];
			if (wr_sbuf && wb_sel_i[1])
				sbuf_r.period <= wb_dat_i[OBG_PER_LSB +: 8];
			// a new write keeps the request alive even on a load edge
			if (wr_sbuf)
				pend_r <= 1'b1;
			else if (load)
				pend_r <= 1'b0;
		end
	end

	// ==========================================================
	// tone engine: phase and duration counters
	localparam int DURW = 16;
	obg_snd_t work_r;
	logic [7:0] phase_r;
	logic [DURW-1:0] dur_r;
	logic out_r;
	wire [DURW-1:0] dur_len = DURW'((32'(tempo_r) + 32'd1) * DUR_UNIT - 1);
	wire run_tick = busy_r && tick_r && !load;
	wire stop = run_tick && (dur_r == '0);
	wire [7:0] phase_nxt = (phase_r == work_r.period) ? 8'h00 : phase_r + 8'h01;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			work_r <= '0;
			phase_r <= '0;
			dur_r <= '0;
			busy_r <= 1'b0;
			out_r <= 1'b0;
		end else if (load) begin
			work_r <= sbuf_r;
			phase_r <= '0;
			dur_r <= dur_len;
			busy_r <= 1'b1;
			out_r <= 1'b1;
		end else if (stop) begin
			busy_r <= 1'b0;
			out_r <= 1'b0;
		end else if (run_tick) begin
			phase_r <= phase_nxt;
			dur_r <= dur_r - 1'b1;
			out_r <= ({2'b00, work_r.high} >= phase_nxt);
		end
	end

	// ==========================================================
	// sticky flags: set beats a clear in the same cycle
	obg_irq_t flag_r;
	obg_irq_t ien_r;
	logic irq_r;
	wire clr_empty = (wr_iclr && wb_dat_i[OBG_ST_EMPTY]) || wr_sbuf;
	wire clr_done = (wr_iclr && wb_dat_i[OBG_ST_DONE]) || wr_sbuf;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			flag_r <= '0;
			ien_r <= '0;
			irq_r <= 1'b0;
		end else begin
			flag_r.empty <= load || (flag_r.empty && !clr_empty);
			flag_r.done <= stop || (flag_r.done && !clr_done);
			if (wr_ien)
				ien_r <= {wb_dat_i[OBG_ST_DONE], wb_dat_i[OBG_ST_EMPTY]};
			irq_r <= |(flag_r & ien_r);
		end
	end

	// ==========================================================
	// read mux; unmapped addresses read zero and still acknowledge
	wire [31:0] stat_word = {29'h0000_0000, busy_r, flag_r.done, flag_r.empty};
	wire [31:0] ien_word = {30'h0000_0000, ien_r.done, ien_r.empty};
	wire [31:0] ctrl_word = {24'h00_0000, tempo_r, 2'h0, mode_r};
	wire [31:0] sbuf_word = {16'h0000, sbuf_r.period, 2'h0, sbuf_r.high};
	wire [31:0] rd_mux = (wb_adr_i == OBG_ADR_CTRL) ? ctrl_word :
		(wb_adr_i == OBG_ADR_SBUF) ? sbuf_word :
		(wb_adr_i == OBG_ADR_STAT) ? stat_word :
		(wb_adr_i == OBG_ADR_IEN) ? ien_word : 32'h0000_0000;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ack_r <= 1'b0;
			rdat_r <= '0;
		end else begin
			ack_r <= bus_req;
			rdat_r <= (bus_req && !wb_we_i) ? rd_mux : 32'h0000_0000;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;
	assign buzzer_out = out_r;
	assign irq = irq_r;

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence s_load;
		load;
	endsequence
	sequence s_flags_up;
		flag_r.empty && busy_r && out_r;
	endsequence

	write_clears_a: assert property (wr_sbuf && !load |=> !flag_r.empty)
		else $error("buffer write did not clear empty flag");
	load_on_tick_a: assert property ($rose(busy_r) |-> $past(tick_r) && $past(pend_r))
		else $error("load happened off the sound tick");
	load_flags_a: assert property (s_load |=> s_flags_up)
		else $error("load did not raise empty and busy");
	idle_quiet_a: assert property (!busy_r |-> !out_r)
		else $error("pin active while idle");
	stop_flags_a: assert property (stop |=> flag_r.done && !busy_r && !out_r)
		else $error("stop did not set done and clear busy");
	high_end_a: assert property (run_tick && phase_r == 8'(work_r.high) && phase_nxt != 8'h00
		|=> !out_r)
		else $error("high time not field plus one");
	period_wrap_a: assert property (run_tick && !stop && phase_r == work_r.period
		|=> phase_r == 8'h00 && out_r)
		else $error("period not field plus one");
	dur_load_a: assert property (s_load |=> dur_r == $past(dur_len))
		else $error("duration count not loaded");
	irq_level_a: assert property (|(flag_r & ien_r) |=> irq_r)
		else $error("interrupt not raised for enabled flag");

	// more checks: pending start, working register hold, empty priority, pin level on every busy cycle, phase range, ack pulse, quiet irq
	write_pends_a: assert property (wr_sbuf |=> pend_r)
		else $error("buffer write left no pending start");
	work_hold_a: assert property (!load |=> $stable(work_r))
		else $error("working register changed without a load");
	empty_wins_a: assert property (load && wr_sbuf |=> flag_r.empty)
		else $error("load lost the empty flag to a buffer write");
	wave_level_a: assert property (busy_r |-> out_r == (phase_r <= {2'b00, work_r.high}))
		else $error("pin level does not match the phase");
	phase_range_a: assert property (busy_r |-> phase_r <= work_r.period)
		else $error("phase ran past the period");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge held longer than one cycle");
	irq_quiet_a: assert property (!(|(flag_r & ien_r)) |=> !irq_r)
		else $error("interrupt raised with no enabled flag");
endmodule : obg_buzzer
`default_nettype wire

// ===== pkg/obg_pkg.sv
package obg_pkg;
	// ==========================================================
	// bus map, byte addresses of 32-bit words
	localparam logic [4:0] OBG_ADR_CTRL = 5'h00;
	localparam logic [4:0] OBG_ADR_SBUF = 5'h04;
	localparam logic [4:0] OBG_ADR_STAT = 5'h08;
	localparam logic [4:0] OBG_ADR_ICLR = 5'h0C;
	localparam logic [4:0] OBG_ADR_IEN = 5'h10;
	// ==========================================================
	// field positions
	localparam int OBG_MODE_LSB = 0;
	localparam int OBG_TEMPO_LSB = 4;
	localparam int OBG_HIGH_LSB = 0;
	localparam int OBG_PER_LSB = 8;
	localparam int OBG_ST_EMPTY = 0;
	localparam int OBG_ST_DONE = 1;
	localparam int OBG_ST_BUSY = 2;
	// ==========================================================
	// modes and reset values
	localparam logic [1:0] OBG_MODE_ONESHOT = 2'h1;
	localparam logic [1:0] OBG_MODE_RST = 2'h0;
	localparam logic [3:0] OBG_TEMPO_RST = 4'h0;
	// ==========================================================
	// timing: sound clock made from the 125 MHz system clock
	localparam int OBG_SYS_HZ = 125000000;
	localparam int OBG_SND_HZ = 32768;
	localparam int OBG_SND_DIV = (OBG_SYS_HZ + OBG_SND_HZ / 2) / OBG_SND_HZ;
	localparam int OBG_DUR_UNIT = 256; // sound ticks per duration step
	// ==========================================================
	// sound buffer contents
	typedef struct packed {
		logic [7:0] period;
		logic [5:0] high;
	} obg_snd_t;
	typedef struct packed {
		logic done;
		logic empty;
	} obg_irq_t;
endpackage : obg_pkg

// ===== tb/obg_piezo_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// piezo load on the tone pin
module obg_piezo_model (
	input wire logic sys_clk, // system clock
	input wire logic pin, // tone pin
	output var int high_cyc, // last high time, system cycles
	output var int per_cyc // last rise-to-rise span
);
	int hc;
	int pc;
	logic pin_d = 1'b0;
	// passive element: it only listens, so it can never bend the tone
	always @(posedge sys_clk) begin
		pin_d <= pin;
		hc <= pin ? hc + 1 : 0;
		if (pin_d && !pin) high_cyc <= hc;
		pc <= (!pin_d && pin) ? 1 : pc + 1;
		if (!pin_d && pin) per_cyc <= pc;
	end
endmodule : obg_piezo_model
`default_nettype wire

// ===== tb/oneshot_buzzer_generator_tb.sv
`timescale 1ns/1ns
`default_nettype none
module oneshot_buzzer_generator_tb;
	import obg_pkg::*;
	localparam int SD = 4;
	localparam int DU = 2;
	// one tone per row: tempo, period, high, then tone cycles, high and period in sys cycles
	typedef struct packed {
		logic [3:0] t;
		logic [7:0] p;
		logic [5:0] h;
		logic [31:0] n_cyc;
		logic [31:0] n_high;
		logic [31:0] n_per;
	} obg_row_t;
	// cycles (tempo+1)*DU*SD+1 from first high sample to irq, high (h+1)*SD, period (p+1)*SD
	obg_row_t rows [3] = '{ // period above high and never zero
		'{4'h7, 8'h03, 6'h01, 32'h0000_0041, 32'h0000_0008, 32'h0000_0010},
		'{4'h7, 8'h07, 6'h03, 32'h0000_0041, 32'h0000_0010, 32'h0000_0020},
		'{4'hf, 8'h05, 6'h00, 32'h0000_0081, 32'h0000_0004, 32'h0000_0018}};
	logic sys_clk, resetn, cyc, stb, we, ack, buzzer_out, irq;
	logic [3:0] sel;
	logic [4:0] adr;
	logic [31:0] dat, rdat, q;
	int err_count, checks, m_high, m_per, n;
	// ==========================================================
	// design and its load
	obg_buzzer #(.SND_DIV(SD), .DUR_UNIT(DU)) DUT (.sys_clk(sys_clk), .resetn(resetn),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .buzzer_out(buzzer_out), .irq(irq));
	obg_piezo_model PZ (.sys_clk(sys_clk), .pin(buzzer_out), .high_cyc(m_high), .per_cyc(m_per));
	// 125 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// ==========================================================
	// shared tasks
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : report_and_stop
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// classic cycle: hold everything until ack is sampled, then let go
	task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hf;
		adr <= a;
		dat <= d;
		do @(posedge sys_clk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	// timing hang guard, far beyond the few hundred cycles needed
	initial begin
		#400000;
		err_count++;
		report_and_stop();
	end
	// ==========================================================
	// main sequence
	initial begin
		{cyc, stb, we, sel, adr, dat, q} = '0;
		resetn = 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		wb(1, OBG_ADR_IEN, 32'h0000_0002);
		foreach (rows[i]) begin
			wb(1, OBG_ADR_CTRL, {24'h0, rows[i].t, 4'h0});
			wb(1, OBG_ADR_SBUF, {16'h0, rows[i].p, 2'b00, rows[i].h});
			wb(0, OBG_ADR_STAT, 32'h0);
			chk(q, 32'h0000_0000);
			wb(1, OBG_ADR_CTRL, {24'h0, rows[i].t, 4'h1});
			n = 0;
			do begin
				@(posedge sys_clk);
				n++;
			end while (buzzer_out !== 1'b1 && n < 50);
			chk({31'h0, buzzer_out}, 32'h0000_0001);
			n = 0;
			do begin
				@(posedge sys_clk);
				n++;
			end while (irq !== 1'b1 && n < 800);
			chk(n, rows[i].n_cyc);
			chk(32'(m_high), rows[i].n_high);
			chk(32'(m_per), rows[i].n_per);
			wb(0, OBG_ADR_STAT, 32'h0);
			chk(q, 32'h0000_0003);
			$display("tone row %0d done", i);
		end
		// masking hides the done flag, clearing drops it
		wb(1, OBG_ADR_IEN, 32'h0000_0000);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h0000_0000);
		wb(1, OBG_ADR_IEN, 32'h0000_0002);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h0000_0001);
		wb(1, OBG_ADR_ICLR, 32'h0000_0003);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h0000_0000);
		$display("interrupt test done");
		// busy and empty show mid-tone, and an enabled empty flag raises irq
		wb(1, OBG_ADR_IEN, 32'h0000_0001);
		wb(1, OBG_ADR_SBUF, 32'h0000_0301);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (buzzer_out !== 1'b1 && n < 50);
		wb(0, OBG_ADR_STAT, 32'h0);
		chk(q, 32'h0000_0005);
		chk({31'h0, irq}, 32'h0000_0001);
		$display("busy test done");
		// second reset lands mid-tone: pin, irq and status must all fall back
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		chk({30'h0, buzzer_out, irq}, 32'h0000_0000);
		wb(0, OBG_ADR_STAT, 32'h0);
		chk(q, 32'h0000_0000);
		wb(0, OBG_ADR_CTRL, 32'h0);
		chk(q, 32'h0000_0000);
		wb(0, OBG_ADR_IEN, 32'h0);
		chk(q, 32'h0000_0000);
		wb(0, 5'h14, 32'h0);
		chk(q, 32'h0000_0000);
		$display("reset test done");
		report_and_stop();
	end
endmodule : oneshot_buzzer_generator_tb
`default_nettype wire
